// *** core/cac_map.svh ***
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define CAC_IP_W       10
`define CAC_IR_W       14
`define CAC_DATA_W     8
`define CAC_IP_RST     10'h03ff
`define CAC_NOP        14'h0000
`define CAC_W_RST      8'h00
`define CAC_FSR_RST    8'h00

// ----------------------------------------------------------------------------
// Special registers mapped into data memory, and status bit positions
// ----------------------------------------------------------------------------
`define CAC_ADDR_IND   8'h00
`define CAC_ADDR_IPL   8'h02
`define CAC_ADDR_STAT  8'h03
`define CAC_ADDR_FSR   8'h04
`define CAC_STAT_C     0
`define CAC_STAT_HB    1
`define CAC_STAT_Z     2

// ----------------------------------------------------------------------------
// Instruction classes, held in the two top opcode bits
// ----------------------------------------------------------------------------
`define CAC_CLS_BYTE   2'h0
`define CAC_CLS_JUMP   2'h2
`define CAC_CLS_LIT    2'h3

`endif

// *** core/cac_pkg.sv ***
`include "cac_map.svh"

package cac_pkg;

  // Four phases of one instruction cycle, one-hot.
  typedef enum logic [3:0] {
    PH_LATCH = 4'h1,
    PH_READ  = 4'h2,
    PH_CALC  = 4'h4,
    PH_WRITE = 4'h8
  } cac_phase_e;

  // Whole state of the core.
  typedef struct packed {
    cac_phase_e             phase;
    logic [`CAC_IP_W-1:0]   ip;
    logic [`CAC_IR_W-1:0]   ir;
    logic [7:0]             w;
    logic                   carry;
    logic                   hb;
    logic                   zero;
    logic [7:0]             fsr;
    logic [7:0]             opnd;
    logic [7:0]             daddr;
    logic [7:0]             wdata;
    logic                   we;
  } cac_state_s;

endpackage : cac_pkg

// *** core/cac_datapath_core.sv ***
`timescale 1ns/1ps
`include "cac_map.svh"

// Notes on behaviour
// - The ALU is eight bits wide and adds, subtracts, shifts and does Boolean operations.
// - Arithmetic results are two's complement unless an instruction says otherwise.
// - Two-operand work pairs the accumulator with a file register or a constant.
// - The accumulator is an eight-bit register that no data address reaches.
// - Instructions update carry, half borrow and zero flags as each one defines.
// - In subtraction the carry and half flags mean no borrow and no half borrow.
// - Instructions are fourteen bits, fetched in one cycle on their own bus.
// - Fetch of the next instruction overlaps execution of the current one.
// - The instruction pointer spans 1K words.
// - Pointer, status and indirection registers sit in data memory, direct or indirect.
// - An instruction that changes the pointer takes two cycles, discarding the prefetch.
// - The clock is divided into four non-overlapping phases per instruction cycle.
// - The operand is read in the second phase and the result written in the fourth.
module cac_datapath_core
  import cac_pkg::*;
(
  input  wire logic                 ref_clk,            // Core clock, 250 MHz.
  input  wire logic                 srst,               // Synchronous reset, high.
  input  wire logic                 ce,                 // Clock enable, low freezes all.
  output logic [`CAC_IP_W-1:0]      prog_addr,          // Program memory word address.
  input  wire logic [`CAC_IR_W-1:0] prog_data,          // Program memory word.
  output logic [7:0]                dmem_addr,          // Data memory byte address.
  input  wire logic [7:0]           dmem_rdata,         // Data memory read data.
  output logic [7:0]                dmem_wdata,         // Data memory write data.
  output logic                      dmem_we,            // Data memory write strobe.
  output logic                      operand_read_phase, // Second phase of the cycle.
  output logic                      result_write_phase  // Fourth phase of the cycle.
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Adder returning {carry, half carry, sum}; subtraction feeds ~b and 1.
  function automatic logic [9:0] cac_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    cac_add = {full[8], lo[4], full[7:0]};
  endfunction : cac_add
  // True for addresses that live inside the core rather than in memory.
  function automatic logic cac_is_sfr(input logic [7:0] a);
    cac_is_sfr = (a == `CAC_ADDR_IND) || (a == `CAC_ADDR_IPL) ||
                 (a == `CAC_ADDR_STAT) || (a == `CAC_ADDR_FSR);
  endfunction : cac_is_sfr

  // --------------------------------------------------------------------------
  // State and reset value
  // --------------------------------------------------------------------------
  localparam cac_state_s ST_RST = '{
    phase: PH_LATCH,
    ip:    `CAC_IP_RST,
    ir:    `CAC_NOP,
    w:     `CAC_W_RST,
    carry: 1'b0,
    hb:    1'b0,
    zero:  1'b0,
    fsr:   `CAC_FSR_RST,
    opnd:  8'h00,
    daddr: 8'h00,
    wdata: 8'h00,
    we:    1'b0
  };
  cac_state_s  s_ff;
  cac_state_s  nxt_s;
  // Decode results, shared by the write strobe and the commit.
  logic [9:0]  sum;
  logic [7:0]  res, lit, rd_mux;
  logic        wr_w, wr_f, upd_z, upd_c, upd_hb, c_new;
  logic        hb_new, skip, go, ip_wr, flush, is_sub;
  assign lit = s_ff.ir[7:0];
  // --------------------------------------------------------------------------
  // Operand mux: core registers answer for their own addresses
  // --------------------------------------------------------------------------
  always_comb begin
    case (s_ff.daddr)
      `CAC_ADDR_IPL:  rd_mux = s_ff.ip[7:0];
      `CAC_ADDR_STAT: rd_mux = {5'h00, s_ff.zero, s_ff.hb, s_ff.carry};
      `CAC_ADDR_FSR:  rd_mux = s_ff.fsr;
      `CAC_ADDR_IND:  rd_mux = 8'h00;  // Indirect through itself reads zero.
      default:        rd_mux = dmem_rdata;
    endcase
  end

  // --------------------------------------------------------------------------
  // Instruction decode and ALU
  // --------------------------------------------------------------------------
  // Runs every cycle; its outputs are only used in the third and fourth
  // phases, when the operand register is already stable.
  always_comb begin
    sum    = 10'h000;
    res    = 8'h00;
    wr_w   = 1'b0;
    wr_f   = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    upd_hb = 1'b0;
    c_new  = 1'b0;
    hb_new = 1'b0;
    skip   = 1'b0;
    go     = 1'b0;
    is_sub = 1'b0;
    case (s_ff.ir[13:12])
      `CAC_CLS_BYTE: begin
        // The d bit picks the file register or the accumulator.
        wr_f = s_ff.ir[7];
        wr_w = ~s_ff.ir[7];
        case (s_ff.ir[11:8])
          4'h0: begin
            res  = s_ff.w;
            wr_w = 1'b0;
          end
          4'h1: upd_z = 1'b1;
          4'h2: begin
            sum    = cac_add(s_ff.opnd, ~s_ff.w, 1'b1);
            res    = sum[7:0];
            is_sub = 1'b1;
            {upd_c, upd_hb, upd_z} = 3'h7;
          end
          4'h3: begin
            res   = s_ff.opnd - 8'h01;
            upd_z = 1'b1;
          end
          4'h4: begin
            res   = s_ff.opnd | s_ff.w;
            upd_z = 1'b1;
          end
          4'h5: begin
            res   = s_ff.opnd & s_ff.w;
            upd_z = 1'b1;
          end
          4'h6: begin
            res   = s_ff.opnd ^ s_ff.w;
            upd_z = 1'b1;
          end
          4'h7: begin
            sum = cac_add(s_ff.opnd, s_ff.w, 1'b0);
            res = sum[7:0];
            {upd_c, upd_hb, upd_z} = 3'h7;
          end
          4'h8: begin
            res   = s_ff.opnd;
            upd_z = 1'b1;
          end
          4'h9: begin
            res   = ~s_ff.opnd;
            upd_z = 1'b1;
          end
          4'ha: begin
            res   = s_ff.opnd + 8'h01;
            upd_z = 1'b1;
          end
          4'hb: begin
            res  = s_ff.opnd - 8'h01;
            skip = (res == 8'h00);
          end
          4'hc: begin
            res   = {s_ff.carry, s_ff.opnd[7:1]};
            upd_c = 1'b1;
          end
          4'hd: begin
            res   = {s_ff.opnd[6:0], s_ff.carry};
            upd_c = 1'b1;
          end
          4'he: res = {s_ff.opnd[3:0], s_ff.opnd[7:4]};
          default: begin
            res  = s_ff.opnd + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
        // Carry out of the shifts is the bit shifted away.
        c_new = (s_ff.ir[11:8] == 4'hc) ? s_ff.opnd[0] :
                (s_ff.ir[11:8] == 4'hd) ? s_ff.opnd[7] : sum[9];
        hb_new = sum[8];
      end
      `CAC_CLS_LIT: begin
        wr_w = 1'b1;
        case (s_ff.ir[11:8])
          4'h0, 4'h1, 4'h2, 4'h3: res = lit;
          4'h8: begin
            res   = lit | s_ff.w;
            upd_z = 1'b1;
          end
          4'h9: begin
            res   = lit & s_ff.w;
            upd_z = 1'b1;
          end
          4'ha: begin
            res   = lit ^ s_ff.w;
            upd_z = 1'b1;
          end
          4'hc, 4'hd: begin
            sum    = cac_add(lit, ~s_ff.w, 1'b1);
            res    = sum[7:0];
            is_sub = 1'b1;
            {upd_c, upd_hb, upd_z} = 3'h7;
          end
          4'he, 4'hf: begin
            sum = cac_add(lit, s_ff.w, 1'b0);
            res = sum[7:0];
            {upd_c, upd_hb, upd_z} = 3'h7;
          end
          default: wr_w = 1'b0;  // Stack returns are not part of this core.
        endcase
        c_new  = sum[9];
        hb_new = sum[8];
      end
      `CAC_CLS_JUMP: go = s_ff.ir[11];
      default: ;
    endcase
  end

  // A write to the pointer, a jump or a taken skip drops the prefetch.
  assign ip_wr = wr_f && (s_ff.daddr == `CAC_ADDR_IPL);
  assign flush = go || ip_wr || skip;

  // --------------------------------------------------------------------------
  // Phase sequencer, fetch and commit
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    case (s_ff.phase)
      PH_LATCH: begin
        nxt_s.phase = PH_READ;
        // Pointer steps here, so the word fetched this cycle is the next one.
        nxt_s.ip    = s_ff.ip + 10'h001;
        nxt_s.daddr = (s_ff.ir[6:0] == 7'h00) ? s_ff.fsr
                                              : {1'b0, s_ff.ir[6:0]};
      end
      PH_READ: begin
        nxt_s.phase = PH_CALC;
        nxt_s.opnd  = rd_mux;
      end
      PH_CALC: begin
        nxt_s.phase = PH_WRITE;
        nxt_s.wdata = res;
        nxt_s.we    = wr_f && !cac_is_sfr(s_ff.daddr);
      end
      PH_WRITE: begin
        nxt_s.phase = PH_LATCH;
        nxt_s.we    = 1'b0;
        if (wr_w) begin
          nxt_s.w = res;
        end
        if (wr_f && s_ff.daddr == `CAC_ADDR_STAT) begin
          nxt_s.carry = res[`CAC_STAT_C];
          nxt_s.hb    = res[`CAC_STAT_HB];
          nxt_s.zero  = res[`CAC_STAT_Z];
        end
        if (wr_f && s_ff.daddr == `CAC_ADDR_FSR) begin
          nxt_s.fsr = res;
        end
        // Flag updates win over a direct write of the status register.
        if (upd_c) begin
          nxt_s.carry = c_new;
        end
        if (upd_hb) begin
          nxt_s.hb = hb_new;
        end
        if (upd_z) begin
          nxt_s.zero = (res == 8'h00);
        end
        // Loads sit one below target because the latch phase steps first.
        if (go) begin
          nxt_s.ip = s_ff.ir[9:0] - 10'h001;
        end else if (ip_wr) begin
          nxt_s.ip = {s_ff.ip[9:8], res} - 10'h001;
        end
        nxt_s.ir = flush ? `CAC_NOP : prog_data;
      end
      default: nxt_s = ST_RST;
    endcase
  end
  // Single register for the whole state; the enable freezes everything.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_ff <= ST_RST;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------------
  assign prog_addr          = s_ff.ip;
  assign dmem_addr          = s_ff.daddr;
  assign dmem_wdata         = s_ff.wdata;
  assign dmem_we            = s_ff.we;
  assign operand_read_phase = s_ff.phase[1];
  assign result_write_phase = s_ff.phase[3];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cac_cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_phase_onehot: assert property ($onehot(s_ff.phase))
    else $error("phase is not one-hot");
  chk_phase_cycle: assert property (
    ce && s_ff.phase == PH_LATCH ##1 ce [*3] |=> s_ff.phase == PH_LATCH)
    else $error("phases do not repeat every four enabled clocks");
  chk_write_phase: assert property (dmem_we |-> result_write_phase)
    else $error("data write outside the fourth phase");
  chk_operand_read: assert property (
    ce && operand_read_phase && !cac_is_sfr(s_ff.daddr)
    |=> s_ff.opnd == $past(dmem_rdata))
    else $error("operand not taken in the second phase");
  chk_ip_step: assert property (
    ce && s_ff.phase == PH_LATCH |=> s_ff.ip == $past(s_ff.ip) + 10'h001)
    else $error("pointer did not step in the first phase");
  chk_fetch_latch: assert property (
    ce && result_write_phase && !flush |=> s_ff.ir == $past(prog_data))
    else $error("fetched word not latched");
  chk_jump_flush: assert property (
    ce && result_write_phase && go
    |=> s_ff.ir == `CAC_NOP ##0 s_ff.ip == $past(s_ff.ir[9:0]) - 10'h001)
    else $error("jump did not discard the prefetch");
  chk_zero_flag: assert property (
    ce && result_write_phase && upd_z |=> s_ff.zero == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  chk_sub_borrow: assert property (
    ce && result_write_phase && is_sub && s_ff.ir[13:12] == `CAC_CLS_BYTE
    |=> s_ff.carry == ($past(s_ff.opnd) >= $past(s_ff.w)))
    else $error("borrow flag wrong after subtraction");
  chk_acc_hold: assert property (
    ce && !(result_write_phase && wr_w) |=> s_ff.w == $past(s_ff.w))
    else $error("accumulator changed without an accumulator write");

endmodule : cac_datapath_core

// *** verif/cac_mem_model.sv ***
`timescale 1ns/1ps
`include "cac_map.svh"

// ----------------------------------------------------------------------------
// Program store and data store seen by the core
// ----------------------------------------------------------------------------
module cac_mem_model
  import cac_pkg::*;
(
  input  wire logic                 ref_clk,    // Core clock.
  input  wire logic                 ce,         // Clock enable.
  input  wire logic [`CAC_IP_W-1:0] prog_addr,  // Program word address.
  output logic [`CAC_IR_W-1:0]      prog_data,  // Program word.
  input  wire logic [7:0]           dmem_addr,  // Data byte address.
  output logic [7:0]                dmem_rdata, // Data read byte.
  input  wire logic [7:0]           dmem_wdata, // Data write byte.
  input  wire logic                 dmem_we     // Data write strobe.
);
  logic [`CAC_IR_W-1:0] rom [0:1023];
  logic [7:0]           ram [0:255];

  // A whole word per fetch over its own bus, across the full 1K space.
  assign prog_data  = rom[prog_addr];
  // The read is combinational so the byte is there in the read phase.
  assign dmem_rdata = ram[dmem_addr];

  // Writes land on the enabled edge that closes the write phase.
  always @(posedge ref_clk) begin
    if (ce && dmem_we) begin
      ram[dmem_addr] <= dmem_wdata;
    end
  end
endmodule : cac_mem_model

// *** verif/test_cpu_alu_datapath_core.sv ***
`timescale 1ns/1ps
`include "cac_map.svh"

// ----------------------------------------------------------------------------
// Program driven test of the core against its two memories
// ----------------------------------------------------------------------------
module test_cpu_alu_datapath_core;
  import cac_pkg::*;
  logic                 ref_clk;
  logic                 srst;
  logic                 ce;
  logic [`CAC_IP_W-1:0] prog_addr;
  logic [`CAC_IR_W-1:0] prog_data;
  logic [7:0]           dmem_addr;
  logic [7:0]           dmem_rdata;
  logic [7:0]           dmem_wdata;
  logic                 dmem_we;
  logic                 operand_read_phase;
  logic                 result_write_phase;
  integer               seed = 19833;
  int                   n_fail;
  int                   checks_done;
  int                   ecnt;
  int                   last_wr;
  int                   last_rd;
  int                   t2d;
  int                   t2b;
  logic                 done;
  logic [7:0]           a;
  logic [7:0]           b;
  int                   p;
  logic [13:0]          prog [$];

  cac_datapath_core i_cac_datapath_core (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .operand_read_phase(operand_read_phase),
    .result_write_phase(result_write_phase)
  );

  cac_mem_model i_cac_mem_model (
    .ref_clk(ref_clk), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we)
  );

  // Free running 4 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task chk8(input logic [7:0] seen, input logic [7:0] exp);
    check({2'h0, seen}, {2'h0, exp});
  endtask : chk8

  task final_report;
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // Encoders for the byte and literal classes.
  function logic [13:0] bop(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {2'h0, op, d, f};
  endfunction : bop

  function logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
    return {2'h3, op, k};
  endfunction : lit

  // Status images {Z,HB,C}; on subtraction C and HB mean no borrow.
  function logic [7:0] add_flags(input logic [7:0] f, input logic [7:0] w);
    logic [8:0] s;
    s = {1'b0, f} + {1'b0, w};
    return {5'h00, s[7:0] == 8'h00, ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0f, s[8]};
  endfunction : add_flags

  function logic [7:0] sub_flags(input logic [7:0] f, input logic [7:0] w);
    return {5'h00, f == w, f[3:0] >= w[3:0], f >= w};
  endfunction : sub_flags

  task put(input logic [13:0] w);
    prog.push_back(w);
  endtask : put

  // Watches the buses on every enabled edge; outputs are registers so the edge value is settled.
  always @(posedge ref_clk) begin
    if (srst) begin
      last_wr = 0;
    end else if (ce) begin
      ecnt++;
      check({9'h000, operand_read_phase & result_write_phase}, 10'h000);
      // The read phase must sit two enabled clocks before the write phase.
      if (operand_read_phase) last_rd = ecnt;
      if (result_write_phase) begin
        if (last_wr > 0) check(10'(ecnt - last_wr), 10'h004);
        check(10'(ecnt - last_rd), 10'h002);
        last_wr = ecnt;
      end
      if (dmem_we) begin
        check({9'h000, result_write_phase}, 10'h001);
        check({9'h000, dmem_addr inside {8'h00, 8'h02, 8'h03, 8'h04}}, 10'h000);
        if (dmem_addr == 8'h2d) t2d = ecnt;
        if (dmem_addr == 8'h2b) begin
          t2b = ecnt;
          done = 1'b1;
        end
      end
    end
  end

  // Hang guard, well beyond eight program runs.
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  // Each pass builds a program from two operands, resets, runs and audits the data store.
  initial begin
    srst = 1'b1;
    ce   = 1'b1;
    for (int it = 0; it < 8; it++) begin
      a = (it == 0) ? 8'hff : (it == 1) ? 8'h0f : 8'($random(seed));
      b = (it == 0) ? 8'h01 : (it == 1) ? 8'h01 : (it == 2) ? a : 8'($random(seed));
      prog.delete();
      put(lit(4'h0, a)); put(bop(4'h0, 1'b1, 7'h20)); put(lit(4'h0, b));
      put(bop(4'h7, 1'b1, 7'h20)); put(bop(4'h8, 1'b0, 7'h03)); put(bop(4'h0, 1'b1, 7'h21));
      put(lit(4'h0, b)); put(bop(4'h0, 1'b1, 7'h22)); put(lit(4'h0, a));
      put(bop(4'h2, 1'b1, 7'h22)); put(bop(4'h8, 1'b0, 7'h03)); put(bop(4'h0, 1'b1, 7'h23));
      put(lit(4'h0, a)); put(lit(4'h8, b)); put(bop(4'h0, 1'b1, 7'h24));
      put(lit(4'h0, a)); put(lit(4'h9, b)); put(bop(4'h0, 1'b1, 7'h25));
      put(lit(4'h0, a)); put(lit(4'ha, b)); put(bop(4'h0, 1'b1, 7'h26));
      put(bop(4'h1, 1'b1, 7'h03)); put(lit(4'h0, a)); put(bop(4'h0, 1'b1, 7'h27));
      put(bop(4'hd, 1'b1, 7'h27)); put(bop(4'h8, 1'b0, 7'h03)); put(bop(4'h0, 1'b1, 7'h28));
      put(lit(4'h0, a)); put(lit(4'h8, 8'h80)); put(lit(4'ha, a | 8'h80));
      put(bop(4'h8, 1'b0, 7'h03)); put(bop(4'h0, 1'b1, 7'h29));
      put(lit(4'h0, 8'h20)); put(bop(4'h0, 1'b1, 7'h04));
      put(bop(4'h8, 1'b0, 7'h00)); put(bop(4'h0, 1'b1, 7'h2c));
      put(lit(4'h0, a)); put(bop(4'h0, 1'b1, 7'h30)); put(bop(4'hc, 1'b1, 7'h30));
      put(bop(4'h0, 1'b1, 7'h31)); put(bop(4'he, 1'b1, 7'h31)); put(bop(4'h0, 1'b1, 7'h32));
      put(bop(4'h9, 1'b1, 7'h32)); put(bop(4'h0, 1'b1, 7'h33)); put(bop(4'ha, 1'b1, 7'h33));
      put(bop(4'h0, 1'b1, 7'h34)); put(bop(4'h3, 1'b1, 7'h34));
      put(lit(4'h0, b)); put(lit(4'hc, a)); put(bop(4'h0, 1'b1, 7'h35));
      put(lit(4'h0, a)); put(lit(4'he, b)); put(bop(4'h0, 1'b1, 7'h36));
      put(lit(4'h0, 8'h01)); put(bop(4'h0, 1'b1, 7'h37)); put(bop(4'hb, 1'b1, 7'h37));
      put(bop(4'h0, 1'b1, 7'h38)); put(bop(4'hf, 1'b1, 7'h37)); put(bop(4'h0, 1'b1, 7'h39));
      p = prog.size();
      put(bop(4'h8, 1'b0, 7'h02)); put(bop(4'h0, 1'b1, 7'h2d));
      put(lit(4'h0, 8'h55)); put({3'h5, 11'(p + 5)}); put(bop(4'h0, 1'b1, 7'h2a));
      put(bop(4'h0, 1'b1, 7'h2b)); put({3'h5, 11'(p + 6)});
      for (int i = 0; i < 1024; i++) i_cac_mem_model.rom[i] = (i < p + 7) ? prog[i] : 14'h0000;
      for (int i = 0; i < 256; i++) i_cac_mem_model.ram[i] = 8'h00;
      @(negedge ref_clk);
      srst = 1'b1;
      ce   = 1'b1;
      repeat (12) @(negedge ref_clk);
      check(prog_addr, 10'h3ff);
      check({1'b0, dmem_we, operand_read_phase, result_write_phase, 6'h00}, 10'h000);
      srst = 1'b0;
      ecnt = 0;
      done = 1'b0;
      for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
        @(negedge ref_clk);
        ce = ($random(seed) % 4) != 0;
      end
      check({9'h000, done}, 10'h001);
      ce = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk8(i_cac_mem_model.ram[8'h20], a + b);
      chk8(i_cac_mem_model.ram[8'h21], add_flags(a, b));
      chk8(i_cac_mem_model.ram[8'h22], b - a);
      chk8(i_cac_mem_model.ram[8'h23], sub_flags(b, a));
      chk8(i_cac_mem_model.ram[8'h24], a | b);
      chk8(i_cac_mem_model.ram[8'h25], a & b);
      chk8(i_cac_mem_model.ram[8'h26], a ^ b);
      chk8(i_cac_mem_model.ram[8'h27], {a[6:0], 1'b0});
      chk8(i_cac_mem_model.ram[8'h28], {5'h00, 2'h2, a[7]});
      chk8(i_cac_mem_model.ram[8'h29], {5'h00, 2'h2, a[7]});
      chk8(i_cac_mem_model.ram[8'h2c], a + b);
      chk8(i_cac_mem_model.ram[8'h30], {a[7], a[7:1]});
      chk8(i_cac_mem_model.ram[8'h31], {a[3:0], a[7:4]});
      chk8(i_cac_mem_model.ram[8'h32], ~a);
      chk8(i_cac_mem_model.ram[8'h33], a + 8'h01);
      chk8(i_cac_mem_model.ram[8'h34], a - 8'h01);
      chk8(i_cac_mem_model.ram[8'h35], a - b);
      chk8(i_cac_mem_model.ram[8'h36], a + b);
      chk8(i_cac_mem_model.ram[8'h37], 8'h01);
      chk8(i_cac_mem_model.ram[8'h38], 8'h00);
      chk8(i_cac_mem_model.ram[8'h39], 8'h01);
      chk8(i_cac_mem_model.ram[8'h2d], 8'(p + 1));
      chk8(i_cac_mem_model.ram[8'h2a], 8'h00);
      chk8(i_cac_mem_model.ram[8'h2b], 8'h55);
      check(10'(t2b - t2d), 10'h010);
    end
    final_report();
  end
endmodule : test_cpu_alu_datapath_core
